// ---- design/gpio_port_pkg.sv ----
// Package with register map, field positions, reset values and bus constants for the port
package gpio_port_pkg;
  localparam int unsigned PORT_WIDTH       = 8;   // Pins in the port
  localparam int unsigned ADDR_WIDTH       = 4;   // Avalon byte address width
  // Register byte offsets
  localparam logic [3:0] OFF_LATCH         = 4'h0; // port_output_latch
  localparam logic [3:0] OFF_DIRECTION     = 4'h4; // port_direction
  localparam logic [3:0] OFF_PULLUP        = 4'h8; // port_pullup_enable
  localparam logic [3:0] OFF_ANALOG_DIS    = 4'hC; // analog_input_disable_low
  // Reset values
  localparam logic [7:0] RST_LATCH         = 8'h00;
  localparam logic [7:0] RST_DIRECTION     = 8'h00;
  localparam logic [7:0] RST_PULLUP        = 8'h00;
  localparam logic [7:0] RST_ANALOG_DIS    = 8'h00;
  // Analog-disable bits that exist (0,1,4,5); others read zero
  localparam logic [7:0] ANALOG_DIS_MASK   = 8'h33;
  // Pins that share analog inputs (4..7)
  localparam logic [7:0] ANALOG_PIN_MASK   = 8'hF0;
  // Pins with external interrupt inputs (0..5)
  localparam logic [7:0] IRQ_PIN_MASK      = 8'h3F;
  // Pin carrying the comparator output and its negative / positive inputs
  localparam int unsigned CMP_OUT_PIN      = 6;
  localparam int unsigned CMP_NEG_PIN      = 5;
  localparam int unsigned CMP_POS_PIN      = 7;
  // Read data answer for an unmapped address
  localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;

  // Bus access phase
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b00,
    BUS_ANSWER = 2'b01
  } bus_state_t;
endpackage : gpio_port_pkg

// ---- design/analog_map.sv ----
// Spreads the packed analog-disable bits onto pins 4..7
`timescale 1ns/100ps
module analog_map (
  input  wire logic        ref_clk,        // Core clock
  input  wire logic        reset,          // Synchronous reset, high
  input  wire logic [7:0]  analog_dis,     // Register view, bits 0,1,4,5 used
  output logic      [7:0]  digital_en_r    // Per pin: digital input enabled
);
  // Registered so that downstream gating sees a clean level
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      digital_en_r <= 8'h0F;  // Analog pins start with digital input off
    end else begin
      digital_en_r <= {analog_dis[5], analog_dis[4], analog_dis[1], analog_dis[0], 4'hF}; // RQ11
    end
  end
endmodule : analog_map

// ---- design/pin_cell.sv ----
// One pin's drive, pull-up and standby input gating
`timescale 1ns/100ps
module pin_cell (
  input  wire logic ref_clk,      // Core clock
  input  wire logic reset,        // Synchronous reset, high
  input  wire logic dir,          // 1 = general output
  input  wire logic latch,        // Output latch bit
  input  wire logic periph_oe,    // Sharing peripheral drives the pin
  input  wire logic periph_out,   // Peripheral output value
  input  wire logic pull_en,      // Pull-up enable bit
  input  wire logic float_now,    // Standby float in force
  input  wire logic keep_input,   // Interrupt keeps input alive in float
  input  wire logic pin_in,       // Pad level
  output logic      pin_out_r,    // Pad drive value
  output logic      pin_oe_r,     // Pad drive enable
  output logic      pull_on_r,    // Pull-up connected
  output logic      in_gated_r    // Input after standby gating
);
  logic drive_en;                 // Pin wanted driven
  logic drive_val;                // Level wanted on the pin

  // Peripheral output wins over the latch; software keeps them exclusive
  always_comb begin
    drive_en  = periph_oe | dir;                    // RQ1 RQ4 RQ7
    drive_val = periph_oe ? periph_out : latch;     // RQ1 RQ2 RQ5 RQ7
  end

  // Pad controls; in float hold nothing, otherwise follow the configuration
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
      pull_on_r <= 1'b0;
    end else begin
      pin_out_r <= drive_val;
      pin_oe_r  <= drive_en & ~float_now;                          // RQ14 RQ16
      // Pull-up is cut whenever the pin drives low, saving current
      pull_on_r <= pull_en & ~float_now & ~(drive_en & ~drive_val); // RQ19
    end
  end

  // Input path locked low in float unless an interrupt needs it
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      in_gated_r <= 1'b0;
    end else begin
      in_gated_r <= pin_in & (~float_now | keep_input);   // RQ14 RQ15
    end
  end
endmodule : pin_cell

// ---- design/gpio_port.sv ----
// Eight-pin I/O port with Avalon-MM register access and analog sharing
`timescale 1ns/100ps
//
// Contract
// RQ1 - Direction one drives pin from latch
// RQ2 - Latch write shows directly on output pins
// RQ3 - Output pin read returns latch value
// RQ4 - Direction zero makes pin an input
// RQ5 - Input pins store latch, do not drive
// RQ6 - Input read gives pin; READ_MODIFY_WRITE gives latch
// RQ7 - Peripheral output enable lets peripheral drive
// RQ8 - Peripheral-driven read gives pin, READ_MODIFY_WRITE latch
// RQ9 - Reads give pin level despite peripheral input
// RQ10 - Software disables other sharing peripheral outputs
// RQ11 - Analog-disable bits 0,1,4,5 map pins 4-7
// RQ12 - Reset clears all direction bits
// RQ13 - Reset clears analog-disable register
// RQ14 - Standby float tristates pins, inputs low
// RQ15 - Enabled interrupt pins keep input in float
// RQ16 - Float bit zero keeps pins in standby
// RQ17 - Software configures analog pins correctly
// RQ18 - Interrupt pins always feed interrupt circuit; in float the code feeds low on pins whose interrupt is disabled
// RQ19 - Pull-up cut while pin drives low
// RQ20 - Comparator input-disable zero enables comparator
// RQ21 - Four byte registers, single bus access
module gpio_port #(
  parameter int unsigned WIDTH = gpio_port_pkg::PORT_WIDTH  // Pins in the port
) (
  input  wire logic        ref_clk,                  // Core clock, 100 MHz
  input  wire logic        reset,                    // Synchronous reset, high
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,              // Byte address
  input  wire logic        avs_read,                 // Read request
  input  wire logic        avs_write,                // Write request
  input  wire logic [31:0] avs_writedata,            // Write data
  input  wire logic [3:0]  avs_byteenable,           // Byte lanes
  input  wire logic        avs_rmw,                  // Read is the first half of a read_modify_write
  output logic      [31:0] avs_readdata,             // Read data
  output logic             avs_waitrequest,          // Stall
  // Pads
  input  wire logic [7:0]  pin_in,                   // Pad levels
  output logic      [7:0]  pin_out,                  // Pad drive values
  output logic      [7:0]  pin_oe,                   // Pad drive enables
  output logic      [7:0]  pull_on,                  // Pull-up connected per pin
  // Peripheral sharing
  input  wire logic [7:0]  periph_oe,                // Peripheral output enables
  input  wire logic [7:0]  periph_out,               // Peripheral output values
  input  wire logic        comparator_digital_out,   // Comparator result for pin 6
  input  wire logic        comparator_out_en,        // Comparator output enable
  input  wire logic        comparator_input_disable, // 0 = comparator inputs enabled
  // Standby
  input  wire logic        standby_pin_float,        // Float pins in stop or watch
  input  wire logic        standby_active,           // Stop or watch mode entered
  input  wire logic [5:0]  ext_irq_enable,           // Interrupt 0..5 enabled
  // Outputs to peripherals
  output logic      [7:0]  port_in_r,                // Gated pin inputs to peripherals
  output logic      [5:0]  ext_irq_in_r,             // Pin levels to interrupt circuit
  output logic      [3:0]  adc_analog_en_r,          // Analog path on pins 4..7
  output logic             comparator_in_en_r        // Comparator inputs connected
);

  // Refuse widths the map cannot serve
  if (WIDTH != 8) begin : g_width_check
    $error("gpio_port supports exactly eight pins");
  end

  // Register state
  logic [7:0] port_output_latch_r;        // Output latch
  logic [7:0] port_direction_r;           // Direction, 1 = output
  logic [7:0] port_pullup_enable_r;       // Pull-up enables
  logic [7:0] analog_input_disable_low_r; // Analog disable, bits 0,1,4,5
  gpio_port_pkg::bus_state_t bus_state_r; // Bus phase
  logic [31:0] readdata_nxt;              // Read mux output
  logic [7:0]  lat_nxt;                   // Next latch value
  logic [7:0]  digital_en_r;              // Digital input enabled per pin
  logic [7:0]  cell_out;                  // Pin cell drive values
  logic [7:0]  cell_oe;                   // Pin cell drive enables
  logic [7:0]  cell_pull;                 // Pin cell pull-ups
  logic [7:0]  cell_in;                   // Pin cell gated inputs
  logic [7:0]  eff_oe;                    // Merged peripheral output enables
  logic [7:0]  eff_out;                   // Merged peripheral output values
  logic [7:0]  keep_in;                   // Inputs kept alive in float
  logic        float_now;                 // Float currently forced
  logic        access;                    // Request being answered now

  // Merge byte lanes into a byte register, lane 0 only carries data
  function automatic logic [7:0] merge_byte(input logic [7:0] old_v,
                                            input logic [31:0] wdata,
                                            input logic [3:0] be);
    merge_byte = be[0] ? wdata[7:0] : old_v;
  endfunction : merge_byte

  // Address decode hit
  function automatic logic hit(input logic [3:0] addr, input logic [3:0] off);
    hit = (addr == off);
  endfunction : hit

  // One wait state: request seen in idle, answered next cycle
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bus_state_r <= gpio_port_pkg::BUS_IDLE;
    end else begin
      case (bus_state_r)
        gpio_port_pkg::BUS_IDLE: begin
          if (avs_read | avs_write) begin
            bus_state_r <= gpio_port_pkg::BUS_ANSWER;
          end
        end
        gpio_port_pkg::BUS_ANSWER: begin
          bus_state_r <= gpio_port_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_r <= gpio_port_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Waitrequest is high except in the answer cycle, registered
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((bus_state_r == gpio_port_pkg::BUS_IDLE) & (avs_read | avs_write));
    end
  end

  assign access = (bus_state_r == gpio_port_pkg::BUS_ANSWER);

  // Latch register, written in one access
  always_comb begin
    lat_nxt = merge_byte(port_output_latch_r, avs_writedata, avs_byteenable);
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_output_latch_r <= gpio_port_pkg::RST_LATCH;
    end else if (access & avs_write & hit(avs_address, gpio_port_pkg::OFF_LATCH)) begin
      port_output_latch_r <= lat_nxt;  // RQ2 RQ5 RQ21
    end
  end

  // Direction register, cleared at reset so every pin is an input
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_direction_r <= gpio_port_pkg::RST_DIRECTION;  // RQ12
    end else if (access & avs_write & hit(avs_address, gpio_port_pkg::OFF_DIRECTION)) begin
      port_direction_r <= merge_byte(port_direction_r, avs_writedata, avs_byteenable); // RQ21
    end
  end

  // Pull-up enable register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_pullup_enable_r <= gpio_port_pkg::RST_PULLUP;
    end else if (access & avs_write & hit(avs_address, gpio_port_pkg::OFF_PULLUP)) begin
      port_pullup_enable_r <= merge_byte(port_pullup_enable_r, avs_writedata, avs_byteenable);
    end
  end

  // Analog-disable register; only four bits exist, the rest read zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_input_disable_low_r <= gpio_port_pkg::RST_ANALOG_DIS;  // RQ13
    end else if (access & avs_write & hit(avs_address, gpio_port_pkg::OFF_ANALOG_DIS)) begin
      analog_input_disable_low_r <= merge_byte(analog_input_disable_low_r, avs_writedata,
                                               avs_byteenable) & gpio_port_pkg::ANALOG_DIS_MASK;
    end
  end

  // Read mux: ordinary latch reads see pins where not output, READ_MODIFY_WRITE reads see the latch
  always_comb begin
    readdata_nxt = gpio_port_pkg::UNMAPPED_DATA;
    case (avs_address)
      gpio_port_pkg::OFF_LATCH: begin
        if (avs_rmw) begin
          readdata_nxt[7:0] = port_output_latch_r;                 // RQ6 RQ8
        end else begin
          // Peripheral-driven or input pins return the sampled level
          readdata_nxt[7:0] = (port_direction_r & ~eff_oe & port_output_latch_r)
                            | (~(port_direction_r & ~eff_oe) & cell_in); // RQ3 RQ6 RQ8 RQ9
        end
      end
      gpio_port_pkg::OFF_DIRECTION:  readdata_nxt[7:0] = port_direction_r;
      gpio_port_pkg::OFF_PULLUP:     readdata_nxt[7:0] = port_pullup_enable_r;
      gpio_port_pkg::OFF_ANALOG_DIS: readdata_nxt[7:0] = analog_input_disable_low_r;
      default:                       readdata_nxt = gpio_port_pkg::UNMAPPED_DATA;
    endcase
  end

  // Read data register, loaded as the request is taken
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((bus_state_r == gpio_port_pkg::BUS_IDLE) & avs_read) begin
      avs_readdata <= readdata_nxt;  // RQ21
    end
  end

  // Comparator output joins the peripheral drive set on its pin
  always_comb begin
    eff_oe  = periph_oe;
    eff_out = periph_out;
    eff_oe[gpio_port_pkg::CMP_OUT_PIN]  = periph_oe[gpio_port_pkg::CMP_OUT_PIN]
                                        | comparator_out_en;   // RQ7
    eff_out[gpio_port_pkg::CMP_OUT_PIN] = comparator_out_en ? comparator_digital_out
                                        : periph_out[gpio_port_pkg::CMP_OUT_PIN];
  end

  // Float applies only in stop or watch with the float bit set
  assign float_now = standby_pin_float & standby_active;  // RQ14 RQ16
  assign keep_in   = {2'b00, ext_irq_enable};             // RQ15

  // Analog-disable fan-out
  analog_map u_analog_map (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .analog_dis   (analog_input_disable_low_r),
    .digital_en_r (digital_en_r)
  );

  // Per-pin cells
  for (genvar i = 0; i < 8; i++) begin : g_pin
    pin_cell u_cell (
      .ref_clk    (ref_clk),
      .reset      (reset),
      .dir        (port_direction_r[i]),
      .latch      (port_output_latch_r[i]),
      .periph_oe  (eff_oe[i]),
      .periph_out (eff_out[i]),
      .pull_en    (port_pullup_enable_r[i]),
      .float_now  (float_now),
      .keep_input (keep_in[i]),
      .pin_in     (pin_in[i]),
      .pin_out_r  (cell_out[i]),
      .pin_oe_r   (cell_oe[i]),
      .pull_on_r  (cell_pull[i]),
      .in_gated_r (cell_in[i])
    );
  end

  // Pad outputs come straight from the cell flip-flops
  assign pin_out = cell_out;
  assign pin_oe  = cell_oe;
  assign pull_on = cell_pull;

  // Peripheral inputs: analog pins with digital input off read low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      port_in_r <= 8'h00;
    end else begin
      port_in_r <= cell_in & digital_en_r;  // RQ11 RQ13
    end
  end

  // Interrupt circuit sees the gated pin level, low in float unless its interrupt is enabled; software masks it when unused
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ext_irq_in_r <= 6'h00;
    end else begin
      ext_irq_in_r <= cell_in[5:0];  // RQ18
    end
  end

  // Analog path on pins 4..7 open while their disable bit is zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      adc_analog_en_r <= 4'hF;
    end else begin
      adc_analog_en_r <= ~digital_en_r[7:4];  // RQ11 RQ13
    end
  end

  // Comparator inputs need both pins' analog-disable at zero and input-disable bit low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      comparator_in_en_r <= 1'b0;
    end else begin
      comparator_in_en_r <= ~comparator_input_disable
                          & ~digital_en_r[gpio_port_pkg::CMP_NEG_PIN]
                          & ~digital_en_r[gpio_port_pkg::CMP_POS_PIN];  // RQ20
    end
  end

endmodule : gpio_port

// ---- dv/gpio_port_asserts.sv ----
// Concurrent checks on the port's bus handshake, pad drive and standby gating
`timescale 1ns/100ps
module gpio_port_asserts (
  input wire logic       ref_clk,           // Core clock
  input wire logic       reset,             // Synchronous reset, high
  input wire logic       avs_read,          // Read request
  input wire logic       avs_write,         // Write request
  input wire logic       avs_waitrequest,   // Stall
  input wire logic [7:0] pin_in,            // Pad levels
  input wire logic [7:0] pin_out,           // Pad drive values
  input wire logic [7:0] pin_oe,            // Pad drive enables
  input wire logic [7:0] pull_on,           // Pull-up connected
  input wire logic [7:0] periph_oe,         // Peripheral output enables
  input wire logic [7:0] periph_out,        // Peripheral output values
  input wire logic       standby_pin_float, // Float pins in standby
  input wire logic       standby_active,    // Stop or watch entered
  input wire logic [5:0] ext_irq_enable,    // Interrupt enables
  input wire logic [7:0] port_in_r,         // Gated inputs
  input wire logic [5:0] ext_irq_in_r,      // Levels to interrupt circuit
  input wire logic [3:0] adc_analog_en_r    // Analog path on pins 4..7
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // A request that the slave has not answered yet
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Float in force for four cycles with steady inputs, long enough for the input lag
  sequence s_float;
    (standby_pin_float && standby_active && $stable(ext_irq_enable) && $stable(pin_in))[*4];
  endsequence
  // Normal mode with a steady peripheral drive
  sequence s_periph;
    (!(standby_pin_float && standby_active) && $stable(periph_oe) && $stable(periph_out))[*3];
  endsequence
  property p_wait_answer;
    s_req |=> !avs_waitrequest;
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("answer not given");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_idle_wait;
    !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("answer without request");
  property p_reset_dir;
    $fell(reset) |-> pin_oe == 8'h00;
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("pin driven after reset");
  property p_reset_ana;
    $fell(reset) |-> adc_analog_en_r == 4'hF;
  endproperty
  a_reset_ana: assert property (p_reset_ana) else $error("analog path off after reset");
  property p_float_drive;
    s_float |-> pin_oe == 8'h00;
  endproperty
  a_float_drive: assert property (p_float_drive) else $error("pin driven in float");
  property p_float_in;
    s_float |-> (port_in_r & ~{2'b00, ext_irq_enable}) == 8'h00;
  endproperty
  a_float_in: assert property (p_float_in) else $error("input not gated low");
  property p_float_keep;
    s_float |-> ((port_in_r ^ pin_in) & {2'b00, ext_irq_enable} & 8'h0F) == 8'h00;
  endproperty
  a_float_keep: assert property (p_float_keep) else $error("irq input blocked");
  property p_irq_feed;
    (!(standby_pin_float && standby_active) && $stable(pin_in))[*3] |->
      ext_irq_in_r == pin_in[5:0];
  endproperty
  a_irq_feed: assert property (p_irq_feed) else $error("irq level not fed");
  property p_pull_cut;
    (pull_on & pin_oe & ~pin_out) == 8'h00;
  endproperty
  a_pull_cut: assert property (p_pull_cut) else $error("pull-up on low drive");
  property p_periph;
    s_periph |-> ((pin_oe & periph_oe & 8'hBF) == (periph_oe & 8'hBF)) &&
      (((pin_out ^ periph_out) & periph_oe & 8'hBF) == 8'h00);
  endproperty
  a_periph: assert property (p_periph) else $error("peripheral not driving");
endmodule : gpio_port_asserts

// ---- dv/pad_model.sv ----
// Pads and board around the port: resolves each pin level
`timescale 1ns/100ps
module pad_model (
  input  wire logic       ref_clk,  // Core clock
  input  wire logic [7:0] pin_out,  // Port drive values
  input  wire logic [7:0] pin_oe,   // Port drive enables
  input  wire logic [7:0] pull_on,  // Pull-ups connected
  input  wire logic [7:0] ext_en,   // Board drives the pin
  input  wire logic [7:0] ext_val,  // Board drive values
  output logic      [7:0] pin_lvl   // Resolved pin levels
);
  logic [7:0] last_r;  // Previous level, so an open pin never holds its value
  // Port drive wins, then the board, then the pull-up; an open pin toggles
  always_comb begin
    pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
              (~pin_oe & ~ext_en & (pull_on | ~last_r));
  end
  // Remember the level for the open-pin case
  always_ff @(posedge ref_clk) begin
    last_r <= pin_lvl;
  end
endmodule : pad_model

// ---- dv/tb.sv ----
// Self-checking bench for the eight-pin port
`timescale 1ns/100ps
module tb;
  localparam logic [3:0] A_LAT = gpio_port_pkg::OFF_LATCH;
  localparam logic [3:0] A_DIR = gpio_port_pkg::OFF_DIRECTION;
  localparam logic [3:0] A_PUL = gpio_port_pkg::OFF_PULLUP;
  localparam logic [3:0] A_ANA = gpio_port_pkg::OFF_ANALOG_DIS;
  logic        ref_clk, reset, avs_read, avs_write, avs_rmw, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, adc_analog_en_r;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, pull_on, periph_oe, periph_out, port_in_r;
  logic [7:0]  ext_en, ext_val;  // Board drive around the pads
  logic        comparator_digital_out, comparator_out_en, comparator_input_disable;
  logic        standby_pin_float, standby_active, comparator_in_en_r;
  logic [5:0]  ext_irq_enable, ext_irq_in_r;
  int          num_errors, samples_checked, cycles;
  int          abit[4] = '{0, 1, 4, 5};  // Analog-disable bit for pins 4..7

  gpio_port u_dut (.*);
  pad_model u_pad (.ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pull_on(pull_on),
                   .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(pin_in));

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Verdict, reached from the end of the tests or from the timeout
  task final_report;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // A hang stops here; the tests need well under this
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      final_report();
    end
  end
  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task settle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : settle
  // One Avalon transfer: hold until waitrequest is sampled low, then release
  task bus(input logic wr, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be,
           input logic read_modify_write);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_rmw <= read_modify_write;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_rmw <= 1'b0;
  endtask : bus
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, 1'b0);
  endtask : wr
  task rdchk(input logic [3:0] a, input logic read_modify_write, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'h0, read_modify_write);
    chk(rd, exp);
  endtask : rdchk

  // Main sequence
  initial begin
    {reset, avs_read, avs_write, avs_rmw} = 4'h8;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    {periph_oe, periph_out, ext_irq_enable} = '0;
    {comparator_digital_out, comparator_out_en, comparator_input_disable} = 3'h1;
    {standby_pin_float, standby_active} = 2'h0;
    ext_en = 8'hFF;
    ext_val = 8'h0C;
    settle(12);
    reset <= 1'b0;
    settle(2);
    chk(32'(pin_oe), 32'h0);
    chk(32'(adc_analog_en_r), 32'hF);
    rdchk(A_DIR, 1'b0, 32'h0);
    rdchk(A_ANA, 1'b0, 32'h0);
    // Register access, unmapped place and a disabled byte lane
    wr(A_DIR, 8'hA5);
    rdchk(A_DIR, 1'b0, 32'hA5);
    wr(A_PUL, 8'h3C);
    rdchk(A_PUL, 1'b0, 32'h3C);
    wr(A_ANA, 8'hFF);
    rdchk(A_ANA, 1'b0, 32'h33);
    wr(4'h2, 8'hFF);
    rdchk(4'h2, 1'b0, 32'h0);
    bus(1'b1, A_DIR, 8'h00, 4'h0, 1'b0);
    rdchk(A_DIR, 1'b0, 32'hA5);
    // Each analog-disable bit frees one pin for digital input
    for (int k = 0; k < 4; k++) begin
      wr(A_ANA, 8'h01 << abit[k]);
      settle(3);
      chk(32'(adc_analog_en_r), 32'(4'hF & ~(4'h1 << k)));
    end
    // Upper pins output, lower pins input read from the board
    wr(A_ANA, 8'h33);
    wr(A_PUL, 8'h00);
    wr(A_DIR, 8'hF0);
    wr(A_LAT, 8'h5A);
    rdchk(A_LAT, 1'b0, 32'h5C);
    chk(32'(pin_oe), 32'hF0);
    chk(32'(pin_out & 8'hF0), 32'h50);
    rdchk(A_LAT, 1'b1, 32'h5A);
    // Peripheral takes the two lowest pins
    @(posedge ref_clk);
    periph_oe <= 8'h03;
    periph_out <= 8'h02;
    settle(4);
    chk(32'(pin_oe), 32'hF3);
    rdchk(A_LAT, 1'b0, 32'h5E);
    rdchk(A_LAT, 1'b1, 32'h5A);
    @(posedge ref_clk);
    periph_oe <= 8'h00;
    // Pull-ups everywhere except where the port drives low
    wr(A_PUL, 8'hFF);
    settle(3);
    chk(32'(pull_on), 32'h5F);
    // Standby without float keeps the outputs
    @(posedge ref_clk);
    standby_active <= 1'b1;
    settle(4);
    chk(32'(pin_oe), 32'hF0);
    chk(32'(pin_out & 8'hF0), 32'h50);
    // Float: all pins released, inputs low except enabled interrupts
    @(posedge ref_clk);
    standby_pin_float <= 1'b1;
    ext_irq_enable <= 6'h05;
    settle(6);
    chk(32'(pin_oe), 32'h0);
    chk(32'(port_in_r), 32'h04);
    @(posedge ref_clk);
    {standby_pin_float, standby_active} <= 2'h0;
    ext_irq_enable <= 6'h00;
    // All inputs: interrupt circuit and reads see the pins
    wr(A_DIR, 8'h00);
    ext_val <= 8'h2D;
    settle(4);
    chk(32'(ext_irq_in_r), 32'h2D);
    chk(32'(port_in_r), 32'h2D);
    rdchk(A_LAT, 1'b0, 32'h2D);
    // Comparator pins 5 and 7 left analog, their pull-ups off
    wr(A_PUL, 8'h5F);
    wr(A_ANA, 8'h11);
    comparator_input_disable <= 1'b0;
    settle(4);
    chk(32'(comparator_in_en_r), 32'h1);
    comparator_input_disable <= 1'b1;
    comparator_out_en <= 1'b1;
    comparator_digital_out <= 1'b1;
    settle(4);
    chk(32'(comparator_in_en_r), 32'h0);
    chk(32'({pin_oe[6], pin_out[6]}), 32'h3);
    // Reset again in mid-run, with every pin driven so the clear is visible
    comparator_out_en <= 1'b0;
    wr(A_DIR, 8'hFF);
    settle(2);
    chk(32'(pin_oe), 32'hFF);
    reset <= 1'b1;
    settle(3);
    reset <= 1'b0;
    settle(2);
    chk(32'(pin_oe), 32'h0);
    rdchk(A_DIR, 1'b0, 32'h0);
    rdchk(A_ANA, 1'b0, 32'h0);
    final_report();
  end
endmodule : tb

bind gpio_port gpio_port_asserts u_chk (.*);
